// File: rtl/irq_host_pkg.sv
// constants for the serial controller interrupt and transfer-request block
package irq_host_pkg;
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 8;
  // register pointers (write side)
  localparam logic [4:0]  A_CMD         = 5'h00;
  localparam logic [4:0]  A_IRQ_CTRL    = 5'h01;
  localparam logic [4:0]  A_VECTOR      = 5'h02;
  localparam logic [4:0]  A_ENHANCE     = 5'h07;
  localparam logic [4:0]  A_MASTER      = 5'h09;
  localparam logic [4:0]  A_EXT_CTRL    = 5'h0F;
  // register pointers (read side)
  localparam logic [4:0]  A_STATUS      = 5'h00;
  localparam logic [4:0]  A_VEC_READ    = 5'h02;
  localparam logic [4:0]  A_PENDING     = 5'h03;
  localparam logic [4:0]  A_SERVICE     = 5'h10;
  localparam logic [4:0]  A_LAST        = 5'h0F;
  // interrupt control fields
  localparam int          IC_EXT_EN     = 0;
  localparam int          IC_TX_EN      = 1;
  localparam int          IC_PAR_SPEC   = 2;
  localparam int          IC_RXM_LO     = 3;
  localparam int          IC_WR_FUNC    = 5;
  localparam int          IC_WR_EN      = 7;
  // enhancement fields
  localparam int          EN_RX_FOUR    = 3;
  localparam int          EN_REQ2_TIME  = 4;
  localparam int          EN_TX_ALL     = 5;
  // master control fields, and the extended-control select bit
  localparam int          MC_VIS        = 0;
  localparam int          MC_MIE        = 3;
  localparam int          MC_VEC_HIGH   = 4;
  localparam int          EXT_ENH_SEL   = 0;
  // command codes in bits 5:3 of the command register
  localparam logic [2:0]  CMD_RESET_IUS = 3'h7;
  localparam logic [2:0]  CMD_SOFT_ACK  = 3'h6;
  localparam logic [2:0]  CMD_RST_EXT   = 3'h2;
  localparam logic [2:0]  CMD_RST_TX    = 3'h5;
  localparam logic [2:0]  CMD_RST_SPEC  = 3'h4;
  // receive interrupt modes
  localparam logic [1:0]  RXM_OFF       = 2'h0;
  localparam logic [1:0]  RXM_FIRST     = 2'h1;
  localparam logic [1:0]  RXM_ALL       = 2'h2;
  localparam logic [1:0]  RXM_SPECIAL   = 2'h3;
  // three-bit vector status codes, then receive threshold, reset values and acknowledge states
  localparam logic [2:0]  ST_TX         = 3'h0;
  localparam logic [2:0]  ST_EXT        = 3'h2;
  localparam logic [2:0]  ST_RX         = 3'h4;
  localparam logic [2:0]  ST_SPEC       = 3'h6;
  localparam logic [2:0]  ST_NONE       = 3'h3;
  localparam logic [3:0]  RX_THRESH     = 4'h4;
  localparam logic [7:0]  MC_RESET      = 8'h00;
  localparam logic [7:0]  IC_RESET      = 8'h00;
  localparam logic [7:0]  ZERO8         = 8'h00;
  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_HELD = 2'b01
  } ack_state_t;
endpackage

// File: rtl/irq_host_ctrl.sv
// interrupt, daisy chain and transfer-request logic of the serial controller
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
module irq_host_ctrl
  import irq_host_pkg::*;
(
  input  wire logic                        CLK,
  input  wire logic                        RESETN,
  input  wire logic [irq_host_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [irq_host_pkg::DATA_W-1:0] WDATA,
  input  wire logic                        WR_STB,
  input  wire logic                        RD_STB,
  output logic      [irq_host_pkg::DATA_W-1:0] RDATA,
  input  wire logic                        ACK_STROBE_N,
  input  wire logic                        ACK_RD_N,
  input  wire logic                        PRIORITY_IN,
  output logic                             PRIORITY_OUT,
  output logic                             IRQ_N_OE,
  output logic      [irq_host_pkg::DATA_W-1:0] ACK_VECTOR,
  output logic                             ACK_VECTOR_OE,
  input  wire logic                        CLEAR_TO_SEND_N,
  input  wire logic                        CARRIER_DETECT_N,
  input  wire logic                        SYNC_N,
  input  wire logic                        TX_UNDERRUN,
  input  wire logic                        BAUD_ZERO,
  input  wire logic                        BREAK_ABORT,
  input  wire logic                        END_OF_POLL,
  input  wire logic                        RX_CHAR_AVAIL,
  input  wire logic [3:0]                  RX_FIFO_LEVEL,
  input  wire logic                        RX_OVERRUN,
  input  wire logic                        RX_FRAMING,
  input  wire logic                        RX_END_OF_FRAME,
  input  wire logic                        RX_PARITY,
  input  wire logic                        TX_TOP_EMPTY,
  input  wire logic                        TX_ALL_EMPTY,
  input  wire logic                        TX_REQ_READY,
  output logic                             WAIT_REQ_N,
  output logic                             WAIT_REQ_OE,
  output logic                             REQ2_N
);
  import irq_host_pkg::*;

  // pin synchronisers; stage one read only by stage two
  logic [6:0] pin_s1, pin_s2, pin_s3;
  logic [6:0] next_pin_s1;
  // register file
  logic [7:0] irq_ctrl, next_irq_ctrl;
  logic [7:0] vector, next_vector;
  logic [7:0] enhance, next_enhance;
  logic [7:0] master, next_master;
  logic [7:0] ext_ctrl, next_ext_ctrl;
  logic [7:0] rdata_q, next_rdata_q;
  // per source: 2 receive, 1 transmit, 0 external/status
  logic [2:0] pending_flag, next_pending_flag;
  logic [2:0] under_service_flag, next_under_service_flag;
  logic       spec_latched, next_spec_latched;
  logic       first_seen, next_first_seen;
  logic [2:0] ack_code, next_ack_code;
  ack_state_t ack_state, next_ack_state;
  logic       irq_q, next_irq_q, prio_q, next_prio_q;
  logic [7:0] ackv_q, next_ackv_q;
  logic       ackv_oe_q, next_ackv_oe_q;
  logic       wr_q, next_wr_q, wr_oe_q, next_wr_oe_q, req2_q, next_req2_q;
  logic       tx_top_d, tx_all_d;

  // status code of the highest requesting source
  function automatic logic [2:0] status_code(input logic [2:0] pend, input logic spec);
    if (pend[2])
      status_code = spec ? ST_SPEC : ST_RX;
    else if (pend[1])
      status_code = ST_TX;
    else if (pend[0])
      status_code = ST_EXT;
    else
      status_code = ST_NONE;
  endfunction

  // put code into the vector, low or high placement
  function automatic logic [7:0] merge_vec(input logic [7:0] v, input logic [2:0] c,
                                           input logic hi);
    merge_vec = hi ? {v[7], c[0], c[1], c[2], v[3:0]} : {v[7:4], c, v[0]};
  endfunction

  // one-hot highest-priority pick
  function automatic logic [2:0] highest(input logic [2:0] v);
    highest = v[2] ? 3'b100 : (v[1] ? 3'b010 : (v[0] ? 3'b001 : 3'b000));
  endfunction

  logic       wr_cmd, wr_irq, wr_vec, wr_enh, wr_mc, wr_ext, soft_ack, reset_ius;
  logic [1:0] rx_mode;
  logic       ext_event, ab_edge, rx_char_ok, spec_cond, tx_event;
  logic       ack_rise_start, ack_active;
  logic [2:0] raw_event, allowed, chain_ok, service_hi;

  always_comb begin
    next_pin_s1 = {END_OF_POLL, BREAK_ABORT, SYNC_N, CARRIER_DETECT_N, CLEAR_TO_SEND_N,
                   ACK_RD_N, ACK_STROBE_N};
    wr_cmd  = WR_STB && ADDR == A_CMD;
    wr_irq  = WR_STB && ADDR == A_IRQ_CTRL;
    wr_vec  = WR_STB && ADDR == A_VECTOR;
    wr_enh  = WR_STB && ADDR == A_ENHANCE && ext_ctrl[EXT_ENH_SEL];
    wr_mc   = WR_STB && ADDR == A_MASTER;
    wr_ext  = WR_STB && ADDR == A_EXT_CTRL;
    soft_ack  = wr_cmd && WDATA[5:3] == CMD_SOFT_ACK;
    reset_ius = wr_cmd && WDATA[5:3] == CMD_RESET_IUS;
    rx_mode = irq_ctrl[IC_RXM_LO +: 2];
    ext_event = (pin_s3[4:2] != pin_s2[4:2]) || TX_UNDERRUN || BAUD_ZERO;
    ab_edge = (pin_s3[6:5] != pin_s2[6:5]);
    ext_event = ext_event || ab_edge;
    spec_cond = RX_OVERRUN || RX_FRAMING || RX_END_OF_FRAME ||
                (RX_PARITY && irq_ctrl[IC_PAR_SPEC]);
    rx_char_ok = enhance[EN_RX_FOUR] ? (RX_FIFO_LEVEL >= RX_THRESH) : RX_CHAR_AVAIL;
    // top byte or whole-FIFO empty, on rising edge
    tx_event = enhance[EN_TX_ALL] ? (TX_ALL_EMPTY && !tx_all_d)
                                  : (TX_TOP_EMPTY && !tx_top_d);
    raw_event = 3'b000;
    unique case (rx_mode)
      RXM_FIRST:   raw_event[2] = (rx_char_ok && !first_seen) || (spec_cond && first_seen);
      RXM_ALL:     raw_event[2] = rx_char_ok || spec_cond;
      RXM_SPECIAL: raw_event[2] = spec_cond;
      RXM_OFF:     raw_event[2] = 1'b0;
    endcase
    raw_event[1] = tx_event;
    raw_event[0] = ext_event;
    allowed = {rx_mode != RXM_OFF, irq_ctrl[IC_TX_EN], irq_ctrl[IC_EXT_EN]} &
              {3{master[MC_MIE]}};
    next_pending_flag = pending_flag;
    if (wr_cmd && WDATA[5:3] == CMD_RST_EXT)
      next_pending_flag[0] = 1'b0;
    if (wr_cmd && WDATA[5:3] == CMD_RST_TX)
      next_pending_flag[1] = 1'b0;
    if (wr_cmd && WDATA[5:3] == CMD_RST_SPEC)
      next_pending_flag[2] = 1'b0;
    // set wins over clear
    next_pending_flag = (next_pending_flag | raw_event) & allowed;
    next_spec_latched = (spec_latched || (raw_event[2] && spec_cond)) && next_pending_flag[2];
    next_first_seen = first_seen;
    if (rx_mode != RXM_FIRST || (wr_cmd && WDATA[5:3] == CMD_RST_SPEC))
      next_first_seen = 1'b0;
    else if (raw_event[2] && rx_char_ok)
      next_first_seen = 1'b1;
    // internal chain: service blocks self and lower
    chain_ok[2] = !under_service_flag[2];
    chain_ok[1] = chain_ok[2] && !pending_flag[2] && !under_service_flag[1];
    chain_ok[0] = chain_ok[1] && !pending_flag[1] && !under_service_flag[0];
    ack_active = !pin_s2[0];
    ack_rise_start = (ack_active && ack_state == ACK_IDLE) || soft_ack;
    next_ack_state = ack_active ? ACK_HELD : ACK_IDLE;
    next_under_service_flag = under_service_flag;
    if (reset_ius)
      next_under_service_flag = under_service_flag & ~highest(under_service_flag);
    next_ack_code = ack_code;
    // service set only with chain in high
    if (ack_rise_start) begin
      if (PRIORITY_IN) begin
        next_under_service_flag = next_under_service_flag |
                                  highest(pending_flag & chain_ok);
        next_ack_code = status_code(pending_flag & chain_ok, spec_latched);
      end
    end
    service_hi = under_service_flag;
    // interrupt when pending, chain in high, not acknowledging
    next_irq_q = |(pending_flag & chain_ok) && PRIORITY_IN && !ack_active &&
                 !ack_rise_start;
    next_prio_q = PRIORITY_IN && !(|service_hi) &&
                  !(ack_active && |(pending_flag & chain_ok));
    // vector onto bus on acknowledge read
    next_ackv_oe_q = ack_active && !pin_s2[1] && PRIORITY_IN;
    next_ackv_q = master[MC_VIS] ? merge_vec(vector, next_ack_code, master[MC_VEC_HIGH])
                                 : vector;
    if (irq_ctrl[IC_WR_FUNC]) begin
      next_wr_q = !(irq_ctrl[IC_WR_EN] && TX_REQ_READY);
      next_wr_oe_q = 1'b1;
    end else begin
      next_wr_q = 1'b0;
      next_wr_oe_q = irq_ctrl[IC_WR_EN] && !TX_REQ_READY;
    end
    next_req2_q = enhance[EN_REQ2_TIME] ? next_wr_q : !(TX_REQ_READY && tx_top_d);
    next_irq_ctrl = wr_irq ? WDATA : irq_ctrl;
    next_vector   = wr_vec ? WDATA : vector;
    next_enhance  = wr_enh ? WDATA : enhance;
    next_master   = wr_mc ? WDATA : master;
    next_ext_ctrl = wr_ext ? WDATA : ext_ctrl;
    next_rdata_q = ZERO8;
    if (RD_STB) begin
      unique case (ADDR)
        A_STATUS:   next_rdata_q = {3'h0, TX_ALL_EMPTY, 1'b0, TX_TOP_EMPTY, 1'b0,
                                    RX_CHAR_AVAIL};
        A_VEC_READ: next_rdata_q = master[MC_VIS] ?
                    merge_vec(vector, status_code(pending_flag, spec_latched),
                              master[MC_VEC_HIGH]) : vector;
        A_PENDING:  next_rdata_q = {2'h0, pending_flag[2], pending_flag[1],
                                    pending_flag[0], 3'h0};
        A_SERVICE:  next_rdata_q = {5'h0, under_service_flag};
        default:    next_rdata_q = ZERO8;
      endcase
    end
  end

  // synchroniser stages and edge-detect history
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      // break and end-of-poll idle low; an all-ones reset would fake an edge
      pin_s1 <= 7'h1F;
      pin_s2 <= 7'h1F;
      pin_s3 <= 7'h1F;
      tx_top_d <= 1'b0;
      tx_all_d <= 1'b0;
    end else begin
      pin_s1 <= next_pin_s1;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      tx_top_d <= TX_TOP_EMPTY;
      tx_all_d <= TX_ALL_EMPTY;
    end
  end

  // host-visible register file and read data
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_ctrl <= IC_RESET;
      vector <= ZERO8;
      enhance <= ZERO8;
      master <= MC_RESET;
      ext_ctrl <= ZERO8;
      rdata_q <= ZERO8;
    end else begin
      irq_ctrl <= next_irq_ctrl;
      vector <= next_vector;
      enhance <= next_enhance;
      master <= next_master;
      ext_ctrl <= next_ext_ctrl;
      rdata_q <= next_rdata_q;
    end
  end

  // pending, service and acknowledge tracking
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pending_flag <= 3'h0;
      under_service_flag <= 3'h0;
      spec_latched <= 1'b0;
      first_seen <= 1'b0;
      ack_code <= ST_NONE;
      ack_state <= ACK_IDLE;
    end else begin
      pending_flag <= next_pending_flag;
      under_service_flag <= next_under_service_flag;
      spec_latched <= next_spec_latched;
      first_seen <= next_first_seen;
      ack_code <= next_ack_code;
      ack_state <= next_ack_state;
    end
  end

  // pin-facing outputs, all registered so no glitch reaches the bus
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_q <= 1'b0;
      prio_q <= 1'b0;
      ackv_q <= ZERO8;
      ackv_oe_q <= 1'b0;
      wr_q <= 1'b0;
      wr_oe_q <= 1'b0;
      req2_q <= 1'b1;
    end else begin
      irq_q <= next_irq_q;
      prio_q <= next_prio_q;
      ackv_q <= next_ackv_q;
      ackv_oe_q <= next_ackv_oe_q;
      wr_q <= next_wr_q;
      wr_oe_q <= next_wr_oe_q;
      req2_q <= next_req2_q;
    end
  end

  assign RDATA         = rdata_q;
  assign PRIORITY_OUT  = prio_q;
  assign IRQ_N_OE      = irq_q;
  assign ACK_VECTOR    = ackv_q;
  assign ACK_VECTOR_OE = ackv_oe_q;
  assign WAIT_REQ_N    = wr_q;
  assign WAIT_REQ_OE   = wr_oe_q;
  assign REQ2_N        = req2_q;
endmodule // irq_host_ctrl

// File: verification/irq_host_ctrl_monitor.sv
// assertion checker for the interrupt and transfer-request block
`timescale 1ns/100ps
module irq_host_ctrl_monitor
  import irq_host_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RESETN,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic              WR_STB,
  input wire logic              RD_STB,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic              ACK_STROBE_N,
  input wire logic              ACK_RD_N,
  input wire logic              PRIORITY_IN,
  input wire logic              PRIORITY_OUT,
  input wire logic              IRQ_N_OE,
  input wire logic              ACK_VECTOR_OE
);
  logic       vis_on;
  logic       mie_on;
  logic [7:0] vec_last;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      vis_on   <= 1'b0;
      mie_on   <= 1'b0;
      vec_last <= 8'h00;
    end else if (WR_STB) begin
      if (ADDR == A_MASTER) vis_on <= WDATA[MC_VIS];
      if (ADDR == A_MASTER) mie_on <= WDATA[MC_MIE];
      if (ADDR == A_VECTOR) vec_last <= WDATA;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_ack_start;
    $fell(ACK_STROBE_N) && IRQ_N_OE;
  endsequence
  chk_vector_readback:
    assert property (RD_STB && ADDR == A_VEC_READ && !vis_on |=> RDATA == vec_last)
    else $error("vector read back differs");
  chk_read_idle_zero:
    assert property (!RD_STB |=> RDATA == 8'h00) else $error("read data outside read slot");
  chk_unmapped_read:
    assert property (RD_STB && ADDR == 5'h1F |=> RDATA == 8'h00) else $error("unmapped read");
  chk_irq_needs_chain:
    assert property (!PRIORITY_IN [*2] |-> !IRQ_N_OE) else $error("irq with chain low");
  chk_chain_out_low:
    assert property (!PRIORITY_IN [*2] |-> !PRIORITY_OUT) else $error("chain out high");
  chk_master_gate:
    assert property (!mie_on [*3] |-> !IRQ_N_OE) else $error("irq without master enable");
  chk_ack_release:
    assert property (s_ack_start |-> ##[1:8] !IRQ_N_OE) else $error("irq held after ack");
  chk_vector_chain:
    assert property (!PRIORITY_IN |=> !ACK_VECTOR_OE) else $error("vector driven, chain low");
  chk_vector_gate:
    assert property (ACK_RD_N [*5] |-> !ACK_VECTOR_OE) else $error("vector driven, no read");
endmodule // irq_host_ctrl_monitor
bind irq_host_ctrl irq_host_ctrl_monitor u_monitor (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR),
  .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
  .ACK_STROBE_N(ACK_STROBE_N), .ACK_RD_N(ACK_RD_N), .PRIORITY_IN(PRIORITY_IN),
  .PRIORITY_OUT(PRIORITY_OUT), .IRQ_N_OE(IRQ_N_OE), .ACK_VECTOR_OE(ACK_VECTOR_OE));

// File: verification/host_ack_model.sv
// host model: chain input, acknowledge strobes and pulled-up interrupt wire
`timescale 1ns/100ps
module host_ack_model (
  input  wire logic       CLK,
  input  wire logic       IRQ_N_OE,
  input  wire logic       ACK_VECTOR_OE,
  input  wire logic [7:0] ACK_VECTOR,
  output logic            ACK_STROBE_N,
  output logic            ACK_RD_N,
  output logic            PRIORITY_IN,
  output wire logic       INT_N
);
  // pull-up wins whenever nobody sinks the wire
  assign INT_N = IRQ_N_OE ? 1'b0 : 1'b1;
  initial begin
    ACK_STROBE_N = 1'b1;
    ACK_RD_N     = 1'b1;
    PRIORITY_IN  = 1'b1;
  end
  task automatic set_chain(input logic v);
    @(posedge CLK);
    PRIORITY_IN <= v;
  endtask
  // strobes held until the vector is seen or the bound runs out
  task automatic ack(output logic [7:0] vec, output logic seen);
    int i;
    seen = 1'b0;
    vec  = 8'h00;
    @(posedge CLK);
    ACK_STROBE_N <= 1'b0;
    ACK_RD_N     <= 1'b0;
    for (i = 0; i < 12 && !seen; i++) begin
      @(posedge CLK);
      if (ACK_VECTOR_OE === 1'b1) begin
        seen = 1'b1;
        vec  = ACK_VECTOR;
      end
    end
    ACK_STROBE_N <= 1'b1;
    ACK_RD_N     <= 1'b1;
  endtask
endmodule // host_ack_model

// File: verification/tb_irq_host_ctrl.sv
// self-checking testbench for the interrupt and transfer-request block
`timescale 1ns/100ps
module tb_irq_host_ctrl;
  import irq_host_pkg::*;
  logic       clk = 1'b0, resetn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic       rx_avail = 1'b0, rx_ovr = 1'b0, tx_top = 1'b0, tx_all = 1'b0;
  logic       req_rdy = 1'b0, wreq_n, wreq_oe, req2_n;
  logic [4:0] addr = 5'h00, pins = 5'h1C;
  logic [7:0] wdata = 8'h00, rdata, ack_vector, vec;
  logic [1:0] evt = 2'h0;
  logic [3:0] rx_level = 4'h0;
  logic       ack_n, ack_rd_n, prio_in, prio_out, irq_oe, vec_oe, int_n, seen;
  int         fails = 0, samples_checked = 0;
  always #20 clk = ~clk;
  irq_host_ctrl u_dut (
    .CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata), .ACK_STROBE_N(ack_n), .ACK_RD_N(ack_rd_n),
    .PRIORITY_IN(prio_in), .PRIORITY_OUT(prio_out), .IRQ_N_OE(irq_oe),
    .ACK_VECTOR(ack_vector), .ACK_VECTOR_OE(vec_oe), .CLEAR_TO_SEND_N(pins[4]),
    .CARRIER_DETECT_N(pins[3]), .SYNC_N(pins[2]), .BREAK_ABORT(pins[1]),
    .END_OF_POLL(pins[0]), .TX_UNDERRUN(evt[1]), .BAUD_ZERO(evt[0]),
    .RX_CHAR_AVAIL(rx_avail), .RX_FIFO_LEVEL(rx_level), .RX_OVERRUN(rx_ovr),
    .RX_FRAMING(1'b0), .RX_END_OF_FRAME(1'b0), .RX_PARITY(1'b0),
    .TX_TOP_EMPTY(tx_top), .TX_ALL_EMPTY(tx_all), .TX_REQ_READY(req_rdy),
    .WAIT_REQ_N(wreq_n), .WAIT_REQ_OE(wreq_oe), .REQ2_N(req2_n));
  host_ack_model u_host (
    .CLK(clk), .IRQ_N_OE(irq_oe), .ACK_VECTOR_OE(vec_oe), .ACK_VECTOR(ack_vector),
    .ACK_STROBE_N(ack_n), .ACK_RD_N(ack_rd_n), .PRIORITY_IN(prio_in), .INT_N(int_n));
  task automatic final_report;
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] c);
    wr(A_CMD, {2'b00, c, 3'b000});
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // bounded wait on the interrupt wire; a timeout ends the run
  task automatic wait_int(input logic lvl);
    int i;
    for (i = 0; i < 20 && int_n !== lvl; i++) @(posedge clk);
    #1 chk({7'h00, int_n}, {7'h00, lvl});
    if (int_n !== lvl) final_report;
  endtask
  task automatic t_vector;
    wr(A_VECTOR, 8'hF1);
    rd_chk(A_VEC_READ, 8'hF1);
    wr(A_IRQ_CTRL, {3'h0, RXM_ALL, 3'h3});
    wr(A_MASTER, 8'h09);
    @(posedge clk) evt <= 2'b01;
    @(posedge clk) evt <= 2'b00;
    rd_chk(A_VEC_READ, 8'hF5);
    @(posedge clk) tx_top <= 1'b1;
    rd_chk(A_VEC_READ, 8'hF1);
    @(posedge clk) rx_avail <= 1'b1;
    rd_chk(A_VEC_READ, 8'hF9);
    rd_chk(A_PENDING, 8'h38);
    @(posedge clk) rx_ovr <= 1'b1;
    rd_chk(A_VEC_READ, 8'hFD);
    @(posedge clk) {rx_avail, rx_ovr, tx_top} <= 3'b000;
    cmd(CMD_RST_EXT);
    cmd(CMD_RST_TX);
    cmd(CMD_RST_SPEC);
    rd_chk(A_PENDING, 8'h00);
  endtask
  task automatic t_ack;
    @(posedge clk) rx_avail <= 1'b1;
    wait_int(1'b0);
    u_host.set_chain(1'b0);
    wait_int(1'b1);
    u_host.set_chain(1'b1);
    wait_int(1'b0);
    u_host.ack(vec, seen);
    chk({7'h00, seen}, 8'h01);
    chk(vec, 8'hF9);
    wait_int(1'b1);
    chk({7'h00, prio_out}, 8'h00);
    cmd(CMD_RESET_IUS);
    wait_int(1'b0);
    chk({7'h00, prio_out}, 8'h01);
    cmd(CMD_SOFT_ACK);
    wait_int(1'b1);
    chk({7'h00, prio_out}, 8'h00);
    cmd(CMD_RESET_IUS);
    @(posedge clk) rx_avail <= 1'b0;
    cmd(CMD_RST_SPEC);
  endtask
  task automatic t_tx;
    wr(A_IRQ_CTRL, 8'h01);
    @(posedge clk) tx_top <= 1'b1;
    rd_chk(A_PENDING, 8'h00);
    @(posedge clk) tx_top <= 1'b0;
    // enhancement write refused while the select bit is clear
    wr(A_ENHANCE, 8'h20);
    wr(A_IRQ_CTRL, 8'h03);
    @(posedge clk) tx_top <= 1'b1;
    rd_chk(A_PENDING, 8'h10);
    @(posedge clk) tx_top <= 1'b0;
    cmd(CMD_RST_TX);
    wr(A_EXT_CTRL, 8'h01);
    wr(A_ENHANCE, 8'h20);
    @(posedge clk) tx_top <= 1'b1;
    rd_chk(A_PENDING, 8'h00);
    @(posedge clk) tx_all <= 1'b1;
    rd_chk(A_PENDING, 8'h10);
    @(posedge clk) {tx_top, tx_all} <= 2'b00;
    cmd(CMD_RST_TX);
  endtask
  task automatic t_ext;
    int k;
    // second pass over the pins returns each to idle
    for (k = 0; k < 12; k++) begin
      @(posedge clk);
      if (k < 10) pins[k % 5] <= ~pins[k % 5];
      else evt[k - 10] <= 1'b1;
      @(posedge clk) evt <= 2'b00;
      repeat (4) @(posedge clk);
      rd_chk(A_PENDING, 8'h08);
      cmd(CMD_RST_EXT);
      rd_chk(A_PENDING, 8'h00);
    end
  endtask
  task automatic t_rx;
    wr(A_ENHANCE, 8'h08);
    wr(A_IRQ_CTRL, {3'h0, RXM_ALL, 3'h3});
    @(posedge clk) {rx_avail, rx_level} <= 5'h13;
    rd_chk(A_PENDING, 8'h00);
    @(posedge clk) rx_level <= 4'h4;
    rd_chk(A_PENDING, 8'h20);
    // level must drop too, or the four-byte event re-arms at once
    @(posedge clk) {rx_avail, rx_level} <= 5'h00;
    cmd(CMD_RST_SPEC);
    wr(A_IRQ_CTRL, {3'h0, RXM_SPECIAL, 3'h3});
    @(posedge clk) rx_avail <= 1'b1;
    rd_chk(A_PENDING, 8'h00);
    @(posedge clk) rx_ovr <= 1'b1;
    rd_chk(A_PENDING, 8'h20);
    @(posedge clk) {rx_avail, rx_ovr} <= 2'b00;
    wr(A_IRQ_CTRL, {3'h0, RXM_FIRST, 3'h3});
    cmd(CMD_RST_SPEC);
    @(posedge clk) rx_ovr <= 1'b1;
    rd_chk(A_PENDING, 8'h00);
    @(posedge clk) {rx_ovr, rx_level} <= 5'h04;
    rd_chk(A_PENDING, 8'h20);
  endtask
  task automatic t_req;
    // request function enabled, no interrupt sources
    wr(A_IRQ_CTRL, 8'hA0);
    @(posedge clk) req_rdy <= 1'b1;
    @(posedge clk) #1 chk({6'h00, wreq_n, wreq_oe}, 8'h01);
    wr(A_ENHANCE, 8'h10);
    @(posedge clk) #1 chk({7'h00, req2_n}, 8'h00);
    @(posedge clk) req_rdy <= 1'b0;
    @(posedge clk) #1 chk({6'h00, wreq_n, req2_n}, 8'h03);
    // wait function: open drain, driven only while not ready
    wr(A_IRQ_CTRL, 8'h80);
    @(posedge clk) #1 chk({6'h00, wreq_n, wreq_oe}, 8'h01);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    chk(rdata, 8'h00);
    resetn <= 1'b1;
    t_vector;
    t_ack;
    t_tx;
    t_ext;
    t_rx;
    t_req;
    final_report;
  end
endmodule // tb_irq_host_ctrl
